// File: src/flash_table_access.v
// Program flash table read/write, row erase and block write control
`include "flash_access_consts.vh"

module flash_table_access #(
  parameter LONG_CYCLES = `LONG_WRITE_CYCLES
) (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // Core register port
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [2:0]  reg_sel_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  // Table instructions
  input  wire        table_read_op_in,
  input  wire        table_write_op_in,
  input  wire [1:0]  ptr_mode_in,
  // Flash array read port
  output reg  [21:0] mem_rd_addr_out,
  input  wire [7:0]  mem_rd_data_in,
  // Flash array program/erase port
  output reg         mem_erase_out,
  output reg         mem_program_out,
  output reg  [21:0] mem_block_addr_out,
  output reg  [63:0] mem_block_data_out,
  // EEPROM read strobe
  output reg         eeprom_read_out,
  // Core status
  output reg         fetch_stall_out,
  output reg         nvm_done_flag_out,
  input  wire        nvm_done_clear_in,
  // Power-on marker and abort flag keeper
  input  wire        por_in,
  output reg         write_abort_flag_out
);

////////////////////////////////////////////////////////////////////////////////
// Pointer arithmetic on the low 21 bits only
function [21:0] ptr_step;
  input [21:0] ptr;
  input        down;
  begin
    if (down)
      ptr_step = {ptr[21], ptr[20:0] - 21'h000001};
    else
      ptr_step = {ptr[21], ptr[20:0] + 21'h000001};
  end
endfunction

// Register port write strobe for one select code
function wr_hit;
  input       wr;
  input [2:0] sel;
  input [2:0] code;
  begin
    wr_hit = wr && (sel == code);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Sequencer states: idle, timed long operation, one-cycle completion
localparam ST_IDLE = 2'h0;
localparam ST_LONG = 2'h1;
localparam ST_DONE = 2'h2;

// Control register fields
reg        prog_sel_reg;
reg        cfg_sel_reg;
reg        row_erase_reg;
reg        unlock_reg;
reg        prog_go_reg;
reg        read_go_reg;

// Table path state
reg [7:0]  table_latch_reg;
reg [21:0] table_pointer_reg;
reg [7:0]  hold_reg [0:`HOLD_COUNT-1];
reg        table_read_op_pend;

// Unlock and long-operation sequencer
reg [1:0]  key_state_reg;
reg [1:0]  state_reg;
reg [31:0] timer_reg;
reg        erase_op_reg;

// Survives rst_n_in so the edge after a reset still sees a running operation
reg        busy_seen_reg;
integer    i;

wire unlocked      = (key_state_reg == 2'h2);
wire ctrl_wr       = wr_hit(reg_wr_in, reg_sel_in, `REG_NVM_CONTROL);
wire start_prog    = ctrl_wr && reg_wdata_in[`BIT_PROG_GO] && unlock_reg && unlocked &&
                     (state_reg == ST_IDLE);
wire start_read    = ctrl_wr && reg_wdata_in[`BIT_READ_GO] && !reg_wdata_in[`BIT_PROG_SEL] &&
                     !prog_go_reg;
wire [21:0] pre_ptr = (ptr_mode_in == `PTR_PRE_INC) ?
                      ptr_step(table_pointer_reg, 1'b0) : table_pointer_reg;
wire [63:0] hold_flat = {hold_reg[7], hold_reg[6], hold_reg[5], hold_reg[4],
                         hold_reg[3], hold_reg[2], hold_reg[1], hold_reg[0]};

////////////////////////////////////////////////////////////////////////////////
// Abort flag survives rst_n_in, cleared by por_in; set if a reset lands mid-operation
// Not cleared by rst_n_in: the first edge in reset must see the old state
always @(posedge ref_clk_in)
begin
  if (por_in)
    busy_seen_reg <= 1'b0;
  else
    busy_seen_reg <= (state_reg == ST_LONG);
end

always @(posedge ref_clk_in)
begin
  if (por_in)
    write_abort_flag_out <= 1'b0;
  else if (!rst_n_in && busy_seen_reg)
    write_abort_flag_out <= 1'b1;
  else if (rst_n_in && ctrl_wr && !reg_wdata_in[`BIT_ABORT])
    write_abort_flag_out <= 1'b0;
end

// Space selects are kept across reset so a failure can be diagnosed
always @(posedge ref_clk_in)
begin
  if (por_in)
  begin
    prog_sel_reg <= 1'b0;
    cfg_sel_reg  <= 1'b0;
  end
  else if (rst_n_in && ctrl_wr)
  begin
    prog_sel_reg <= reg_wdata_in[`BIT_PROG_SEL];
    cfg_sel_reg  <= reg_wdata_in[`BIT_CFG_SEL];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control, unlock sequence and long-write timer
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    row_erase_reg      <= 1'b0;
    unlock_reg         <= 1'b0;
    prog_go_reg        <= 1'b0;
    read_go_reg        <= 1'b0;
    key_state_reg      <= 2'h0;
    state_reg          <= ST_IDLE;
    timer_reg          <= 32'h00000000;
    erase_op_reg       <= 1'b0;
    fetch_stall_out    <= 1'b0;
    mem_erase_out      <= 1'b0;
    mem_program_out    <= 1'b0;
    mem_block_addr_out <= 22'h000000;
    mem_block_data_out <= 64'h0000000000000000;
    eeprom_read_out    <= 1'b0;
    nvm_done_flag_out  <= 1'b0;
  end
  else
  begin
    mem_erase_out   <= 1'b0;
    mem_program_out <= 1'b0;
    eeprom_read_out <= 1'b0;

    // Unlock key: 55h then AAh, then program go on a control write that is the very next register write
    if (wr_hit(reg_wr_in, reg_sel_in, `REG_NVM_UNLOCK_KEY))
    begin
      if (reg_wdata_in == `KEY_FIRST)
        key_state_reg <= 2'h1;
      else if (reg_wdata_in == `KEY_SECOND && key_state_reg == 2'h1)
        key_state_reg <= 2'h2;
      else
        key_state_reg <= 2'h0;
    end
    else if (reg_wr_in)
      key_state_reg <= 2'h0;

    // Plain control fields
    if (ctrl_wr)
    begin
      row_erase_reg <= reg_wdata_in[`BIT_ROW_ERASE];
      unlock_reg    <= reg_wdata_in[`BIT_UNLOCK];
    end

    // One-cycle EEPROM read, hardware clears
    if (start_read)
    begin
      read_go_reg     <= 1'b1;
      eeprom_read_out <= 1'b1;
    end
    else
      read_go_reg <= 1'b0;

    // Long write or erase sequencer
    case (state_reg)
      ST_IDLE:
      begin
        if (start_prog)
        begin
          prog_go_reg     <= 1'b1;
          fetch_stall_out <= 1'b1;
          erase_op_reg    <= reg_wdata_in[`BIT_ROW_ERASE];
          timer_reg       <= 32'h00000000;
          state_reg       <= ST_LONG;
        end
      end
      ST_LONG:
      begin
        // Unlock may be cleared here without effect
        if (timer_reg == LONG_CYCLES - 1)
          state_reg <= ST_DONE;
        else
          timer_reg <= timer_reg + 32'h00000001;
      end
      ST_DONE:
      begin
        if (erase_op_reg)
        begin
          mem_erase_out      <= 1'b1;
          mem_block_addr_out <= {table_pointer_reg[21:6], 6'h00};
          row_erase_reg      <= 1'b0;
        end
        else
        begin
          mem_program_out    <= 1'b1;
          mem_block_addr_out <= {table_pointer_reg[21:3], 3'h0};
          mem_block_data_out <= hold_flat;
        end
        prog_go_reg       <= 1'b0;
        fetch_stall_out   <= 1'b0;
        nvm_done_flag_out <= 1'b1;
        state_reg         <= ST_IDLE;
      end
      default:
        state_reg <= ST_IDLE;
    endcase

    // Completion wins over a clear in the same cycle
    if (nvm_done_clear_in && state_reg != ST_DONE)
      nvm_done_flag_out <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Table latch, pointer and holding registers
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    table_latch_reg   <= 8'h00;
    table_pointer_reg <= 22'h000000;
    mem_rd_addr_out   <= 22'h000000;
    for (i = 0; i < `HOLD_COUNT; i = i + 1)
      hold_reg[i] <= 8'hFF;
  end
  else
  begin
    // Core writes to the latch and pointer bytes
    if (wr_hit(reg_wr_in, reg_sel_in, `REG_TABLE_LATCH))
      table_latch_reg <= reg_wdata_in;
    if (wr_hit(reg_wr_in, reg_sel_in, `REG_PTR_LOW))
      table_pointer_reg[7:0] <= reg_wdata_in;
    if (wr_hit(reg_wr_in, reg_sel_in, `REG_PTR_HIGH))
      table_pointer_reg[15:8] <= reg_wdata_in;
    if (wr_hit(reg_wr_in, reg_sel_in, `REG_PTR_UPPER))
      table_pointer_reg[21:16] <= reg_wdata_in[5:0];

    // Table operation: address out, holding register, pointer update
    if (table_read_op_in || table_write_op_in)
    begin
      mem_rd_addr_out <= pre_ptr;
      if (table_write_op_in)
        hold_reg[pre_ptr[2:0]] <= table_latch_reg;
      case (ptr_mode_in)
        `PTR_POST_INC: table_pointer_reg <= ptr_step(table_pointer_reg, 1'b0);
        `PTR_POST_DEC: table_pointer_reg <= ptr_step(table_pointer_reg, 1'b1);
        `PTR_PRE_INC:  table_pointer_reg <= pre_ptr;
        default:       table_pointer_reg <= table_pointer_reg;
      endcase
    end
    else if (table_read_op_pend)
      table_latch_reg <= mem_rd_data_in;
  end
end

// Read data returns one cycle after the address is presented
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
    table_read_op_pend <= 1'b0;
  else
    table_read_op_pend <= table_read_op_in;
end

////////////////////////////////////////////////////////////////////////////////
// Register read-back
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
    reg_rdata_out <= 8'h00;
  else if (reg_rd_in)
  begin
    case (reg_sel_in)
      `REG_NVM_CONTROL:
        reg_rdata_out <= {prog_sel_reg, cfg_sel_reg, 1'b0, row_erase_reg,
                          write_abort_flag_out, unlock_reg, prog_go_reg, read_go_reg};
      `REG_NVM_UNLOCK_KEY: reg_rdata_out <= 8'h00;
      `REG_TABLE_LATCH:    reg_rdata_out <= table_latch_reg;
      `REG_PTR_LOW:        reg_rdata_out <= table_pointer_reg[7:0];
      `REG_PTR_HIGH:       reg_rdata_out <= table_pointer_reg[15:8];
      `REG_PTR_UPPER:      reg_rdata_out <= {2'h0, table_pointer_reg[21:16]};
      default:             reg_rdata_out <= 8'h00;
    endcase
  end
end

endmodule // flash_table_access

// File: src/flash_access_consts.vh
// Constants for the program flash table access block
`ifndef FLASH_ACCESS_CONSTS_VH
`define FLASH_ACCESS_CONSTS_VH
// Register select codes on the core register port
`define REG_NVM_CONTROL    3'h0
`define REG_NVM_UNLOCK_KEY 3'h1
`define REG_TABLE_LATCH    3'h2
`define REG_PTR_LOW        3'h3
`define REG_PTR_HIGH       3'h4
`define REG_PTR_UPPER      3'h5
// Control register bit positions
`define BIT_PROG_SEL  7
`define BIT_CFG_SEL   6
`define BIT_ROW_ERASE 4
`define BIT_ABORT     3
`define BIT_UNLOCK    2
`define BIT_PROG_GO   1
`define BIT_READ_GO   0
// Pointer update modes
`define PTR_KEEP     2'h0
`define PTR_POST_INC 2'h1
`define PTR_POST_DEC 2'h2
`define PTR_PRE_INC  2'h3
// Unlock key bytes
`define KEY_FIRST  8'h55
`define KEY_SECOND 8'hAA
// Geometry
`define PTR_WIDTH  22
`define HOLD_COUNT 8
// Long write time
`define LONG_WRITE_NS 2000000
`define CLK_PERIOD_NS 5
`define LONG_WRITE_CYCLES (`LONG_WRITE_NS / `CLK_PERIOD_NS)
`endif

// File: tb/flash_array_model.sv
// Behavioural flash array that answers any byte address at once
module flash_array_model (
  input  wire [21:0] addr_in,
  output wire [7:0]  data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Top pointer bit alters the byte so configuration space is told apart
  assign data_out = addr_in[7:0] ^ {addr_in[21], 7'h3C};
endmodule // flash_array_model

// File: tb/flash_table_access_chk.sv
// Assertion checker on the ports of the flash table access block
module flash_table_access_chk #(
  parameter LONG_CYCLES = 8
) (
  input wire       ref_clk_in,
  input wire       rst_n_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [2:0] reg_sel_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire       mem_erase_out,
  input wire       mem_program_out,
  input wire       eeprom_read_out,
  input wire       fetch_stall_out,
  input wire       nvm_done_flag_out,
  input wire       nvm_done_clear_in,
  input wire       por_in,
  input wire       write_abort_flag_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_STALL_HOLD: assert property ($rose(fetch_stall_out) |-> fetch_stall_out[*4])
    else $error("stall ended early");
  AST_STALL_END: assert property ($fell(fetch_stall_out) |-> mem_program_out || mem_erase_out)
    else $error("stall ended without array operation");
  AST_PROG_DONE: assert property ($rose(mem_program_out) |-> nvm_done_flag_out)
    else $error("done flag missing at program");
  AST_PROG_PULSE: assert property (mem_program_out |=> !mem_program_out)
    else $error("program strobe too long");
  AST_KEY_ZERO: assert property (reg_rd_in && reg_sel_in == 3'h1 |=> reg_rdata_out == 8'h00)
    else $error("unlock key read not zero");
  AST_EE_IGNORED: assert property (reg_wr_in && reg_sel_in == 3'h0 && reg_wdata_in[7]
    |=> !eeprom_read_out [*2])
    else $error("eeprom read with flash selected");
  AST_DONE_HOLD: assert property (nvm_done_flag_out && !nvm_done_clear_in |=> nvm_done_flag_out)
    else $error("done flag lost");
  AST_ABORT_KEEP: assert property (write_abort_flag_out && !por_in &&
    !(reg_wr_in && reg_sel_in == 3'h0 && !reg_wdata_in[3]) |=> write_abort_flag_out)
    else $error("abort flag lost");
endmodule // flash_table_access_chk

bind flash_table_access flash_table_access_chk #(.LONG_CYCLES(LONG_CYCLES)) chk (.*);

// File: tb/tb_flash_table_access.sv
// Self-checking testbench for the flash table access block
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_flash_table_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, por_in = 1'b1;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, nvm_done_clear_in = 1'b0;
  logic        table_read_op_in = 1'b0, table_write_op_in = 1'b0;
  logic [2:0]  reg_sel_in = 3'h0;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [1:0]  ptr_mode_in = 2'h0;
  wire  [7:0]  reg_rdata_out, mem_rd_data_in;
  wire  [21:0] mem_rd_addr_out, mem_block_addr_out;
  wire  [63:0] mem_block_data_out;
  wire         mem_erase_out, mem_program_out, eeprom_read_out;
  wire         fetch_stall_out, nvm_done_flag_out, write_abort_flag_out;
  logic [21:0] blk_addr;
  logic [63:0] blk_data;
  int          fail_count = 0, num_checks = 0, prog_cnt = 0, ers_cnt = 0, ee_cnt = 0;

  flash_table_access #(.LONG_CYCLES(8)) uut (.*);
  flash_array_model mem (.addr_in(mem_rd_addr_out), .data_out(mem_rd_data_in));

  initial
  begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    ee_cnt += (eeprom_read_out === 1'b1);
    if (mem_program_out === 1'b1 || mem_erase_out === 1'b1)
    begin
      prog_cnt += mem_program_out;
      ers_cnt += mem_erase_out;
      blk_addr = mem_block_addr_out;
      blk_data = mem_block_data_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic [7:0] fe(input [21:0] a);
    fe = a[7:0] ^ {a[21], 7'h3C};
  endfunction
  task automatic wr(input [2:0] s, input [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_sel_in <= s;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input [2:0] s, input [7:0] m, input [7:0] e);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_sel_in <= s;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(reg_rdata_out & m, e)
  endtask
  task automatic top(input w, input [1:0] m);
    @(posedge ref_clk_in);
    table_write_op_in <= w;
    table_read_op_in <= !w;
    ptr_mode_in <= m;
    @(posedge ref_clk_in);
    table_write_op_in <= 1'b0;
    table_read_op_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic setp(input [21:0] a);
    wr(3, a[7:0]);
    wr(4, a[15:8]);
    wr(5, {2'h0, a[21:16]});
  endtask
  task automatic start(input [7:0] c);
    wr(0, c);
    wr(1, 8'h55);
    wr(1, 8'hAA);
    wr(0, c | 8'h02);
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic settle;
    for (int i = 0; i < 40 && fetch_stall_out !== 1'b0; i++) @(posedge ref_clk_in);
    repeat (2) @(posedge ref_clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_read;
    setp(22'h3FFFFF);
    top(0, 2'h1);
    rdc(2, 8'hFF, fe(22'h3FFFFF));
    rdc(3, 8'hFF, 8'h00);
    rdc(5, 8'hFF, 8'h20);
    setp(22'h0012FF);
    top(0, 2'h3);
    rdc(2, 8'hFF, fe(22'h001300));
    top(0, 2'h2);
    rdc(2, 8'hFF, fe(22'h001300));
    top(0, 2'h0);
    rdc(2, 8'hFF, fe(22'h0012FF));
    rdc(4, 8'hFF, 8'h12);
    rdc(1, 8'hFF, 8'h00);
  endtask
  task automatic t_refuse;
    wr(0, 8'h82);
    rdc(0, 8'h02, 8'h00);
    `CHK(fetch_stall_out, 1'b0)
    wr(0, 8'h81);
    wr(0, 8'h01);
    rdc(0, 8'h81, 8'h00);
    `CHK(ee_cnt, 1)
  endtask
  task automatic t_write;
    setp(22'h00040D);
    for (int k = 0; k < 8; k++)
    begin
      wr(2, 8'h10 + 8'(k));
      top(1, 2'h1);
    end
    `CHK(prog_cnt, 0)
    start(8'h84);
    `CHK(fetch_stall_out, 1'b1)
    wr(0, 8'h80);
    settle;
    `CHK(prog_cnt, 1)
    `CHK(blk_addr[21:3], 19'h00082)
    for (int j = 0; j < 8; j++) `CHK(blk_data[8*j +: 8], 8'(16 + ((j + 3) & 7)))
    `CHK(nvm_done_flag_out, 1'b1)
    rdc(0, 8'h02, 8'h00);
    nvm_done_clear_in <= 1'b1;
    @(posedge ref_clk_in);
    nvm_done_clear_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(nvm_done_flag_out, 1'b0)
  endtask
  task automatic t_erase;
    setp(22'h00127F);
    start(8'h94);
    settle;
    `CHK(ers_cnt, 1)
    `CHK(blk_addr[21:6], 16'h0049)
    `CHK(prog_cnt, 1)
    rdc(0, 8'h10, 8'h00);
  endtask
  task automatic t_abort;
    start(8'h84);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rdc(0, 8'h88, 8'h88);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    por_in <= 1'b0;
    t_read;
    t_refuse;
    t_write;
    t_erase;
    t_abort;
    final_report;
  end
  initial
  begin
    #20000;
    fail_count++;
    final_report;
  end
endmodule // tb_flash_table_access
